// ### core/stc_translation_ctrl.sv
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module stc_translation_ctrl #(
    parameter int XLEN = 64,
    parameter int ID_BITS = 16,
    parameter int PG_BITS = 44,
    parameter logic [15:0] SCHEME_MASK = 16'h0701
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [0:0] i_addr,
    input wire logic [XLEN-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [XLEN-1:0] o_rdata,
    input wire logic [1:0] i_priv,
    input wire logic i_req,
    input wire logic [XLEN-1:0] i_vaddr,
    input wire logic i_walk_done,
    input wire logic i_fence,
    output logic o_active,
    output logic o_walk_busy,
    output logic o_start,
    output logic o_bare,
    output logic [XLEN-1:0] o_paddr,
    output logic [XLEN-1:0] o_root,
    output logic [15:0] o_ident,
    output logic [3:0] o_sel
);
    localparam bit WIDE = (XLEN == 64);
    localparam int ID_LIMIT = WIDE ? stc_pkg::WIDE_ID_MAX : stc_pkg::NARROW_ID_MAX;
    localparam int PG_LIMIT = WIDE ? stc_pkg::WIDE_PG_BITS : stc_pkg::NARROW_PG_BITS;
    localparam int IP = WIDE ? stc_pkg::WIDE_ID_POS : stc_pkg::NARROW_ID_POS;
    initial begin
        if (XLEN != 32 && XLEN != 64) $error("width must be 32 or 64");
        if (ID_BITS < 0 || ID_BITS > ID_LIMIT) $error("identifier width too large");
        if (PG_BITS < 1 || PG_BITS > PG_LIMIT) $error("page field width out of range");
        if (!SCHEME_MASK[0]) $error("no-translation must be supported");
    end
    logic [XLEN-1:0] reg_q, reg_d, rdata_q, rdata_d;
    logic [3:0] sel_q, sel_d;
    logic [15:0] id_q, id_d;
    logic legal;
    logic [3:0] new_sel;
    logic [15:0] new_id;
    logic [XLEN-1:0] new_val;
    logic [XLEN-1:0] pg_mask;
    stc_legalise #(
        .XLEN(XLEN),
        .ID_BITS(ID_BITS),
        .PG_BITS(PG_BITS),
        .SCHEME_MASK(SCHEME_MASK)
    ) u_legal (
        .i_wdata(i_wdata),
        .o_legal(legal),
        .o_sel(new_sel),
        .o_ident(new_id),
        .o_value(new_val)
    );
    always_comb begin
        reg_d = reg_q;
        sel_d = sel_q;
        id_d = id_q;
        rdata_d = '0;
        // Write leaves walks and cached translations alone; software fences
        if (i_wr && i_addr == stc_pkg::ADDR_REG && legal) begin
            reg_d = new_val;
            sel_d = new_sel;
            id_d = new_id;
        end
        if (i_rd && i_addr == stc_pkg::ADDR_REG) begin
            rdata_d = reg_q;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            reg_q <= '0;
            sel_q <= stc_pkg::RESET_SEL;
            id_q <= '0;
            rdata_q <= '0;
        end else begin
            reg_q <= reg_d;
            sel_q <= sel_d;
            id_q <= id_d;
            rdata_q <= rdata_d;
        end
    end
    stc_cfg_if #(.WIDTH(XLEN)) cfg ();
    always_comb begin
        pg_mask = XLEN'(({(XLEN+1){1'b0}} | 1) << PG_BITS) - XLEN'(1);
        cfg.sel = sel_q;
        cfg.ident = id_q;
        // Root address is page number times the 4 KiB page
        cfg.root_addr = (reg_q & pg_mask) << stc_pkg::PAGE_SHIFT;
        cfg.active = (i_priv == stc_pkg::PRIV_SUPER) || (i_priv == stc_pkg::PRIV_USER);
    end
    stc_walk_gate #(.WIDTH(XLEN)) u_gate (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .cfg(cfg),
        .i_req(i_req),
        .i_vaddr(i_vaddr),
        .i_walk_done(i_walk_done),
        .i_fence(i_fence),
        .o_start(o_start),
        .o_bare(o_bare),
        .o_paddr(o_paddr),
        .o_root(o_root),
        .o_ident(o_ident),
        .o_sel(o_sel)
    );
    assign o_rdata = rdata_q;
    assign o_active = cfg.active;
    assign o_walk_busy = cfg.walk_busy;
endmodule

// ### shared/stc_pkg.sv
// Behaviour
// - Narrow layout: selector 31, identifier 30:22, page 21:0
// - Wide layout: selector 63:60, identifier 59:44, page 43:0
// - Page number is root address over 4 KiB
// - Narrow selector 0 none, 1 paged 32-bit
// - Wide selector 0 none, 8/9/10 paged schemes
// - Wide 1-7, 11-13 reserved, 14-15 custom
// - No-translation passes addresses unchanged, no protection
// - No-translation encodings custom or reserved per width
// - Unsupported selector write is discarded whole
// - Identifier bits implemented from the bottom
// - Identifier width at most 9 or 16
// - Page field reads back only legal values
// - Translations start only while register active
// - Started translations may finish after deactivation
// - Writes neither order nor invalidate cached translations
// - Identifier and page number change together
package stc_pkg;
    localparam int NARROW_SEL_POS = 31;
    localparam int NARROW_ID_POS = 22;
    localparam int NARROW_ID_MAX = 9;
    localparam int NARROW_PG_BITS = 22;
    localparam int WIDE_SEL_POS = 60;
    localparam int WIDE_SEL_BITS = 4;
    localparam int WIDE_ID_POS = 44;
    localparam int WIDE_ID_MAX = 16;
    localparam int WIDE_PG_BITS = 44;
    localparam int PAGE_SHIFT = 12;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_P32 = 4'h1;
    localparam logic [3:0] SEL_P39 = 4'h8;
    localparam logic [3:0] SEL_P48 = 4'h9;
    localparam logic [3:0] SEL_P57 = 4'hA;
    localparam logic [3:0] RESET_SEL = 4'h0;
    localparam logic [0:0] ADDR_REG = 1'h0;
    localparam int ACCESS_LATENCY = 1;
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    typedef enum {
        STC_IDLE,
        STC_WALK
    } stc_walk_type;
endpackage

// ### shared/stc_cfg_if.sv
`timescale 1ns/1ps
interface stc_cfg_if #(
    parameter int WIDTH = 64
);
    logic [3:0] sel;
    logic [15:0] ident;
    logic [WIDTH-1:0] root_addr;
    logic active;
    logic walk_busy;
    modport src (output sel, output ident, output root_addr, output active, input walk_busy);
    modport snk (input sel, input ident, input root_addr, input active, output walk_busy);
endinterface

// ### core/stc_legalise.sv
`timescale 1ns/1ps
module stc_legalise #(
    parameter int XLEN = 64,
    parameter int ID_BITS = 16,
    parameter int PG_BITS = 44,
    parameter logic [15:0] SCHEME_MASK = 16'h0701
) (
    input wire logic [XLEN-1:0] i_wdata,
    output logic o_legal,
    output logic [3:0] o_sel,
    output logic [15:0] o_ident,
    output logic [XLEN-1:0] o_value
);
    localparam bit WIDE = (XLEN == 64);
    localparam int SP = WIDE ? stc_pkg::WIDE_SEL_POS : stc_pkg::NARROW_SEL_POS;
    localparam int IP = WIDE ? stc_pkg::WIDE_ID_POS : stc_pkg::NARROW_ID_POS;
    logic [3:0] sel;
    logic [15:0] raw_id;
    logic [15:0] id_mask;
    logic [XLEN-1:0] pg_mask;
    always_comb begin
        if (WIDE) begin
            sel = 4'(i_wdata >> SP);
        end else begin
            sel = {3'h0, i_wdata[SP]};
        end
        raw_id = 16'(i_wdata >> IP);
        id_mask = 16'((17'h1 << ID_BITS) - 17'h1);
        pg_mask = XLEN'(({(XLEN+1){1'b0}} | 1) << PG_BITS) - XLEN'(1);
        // Reserved and custom selectors are simply absent from the support mask
        o_legal = SCHEME_MASK[sel];
        o_sel = sel;
        o_ident = raw_id & id_mask;
        o_value = (XLEN'(sel) << SP) | (XLEN'(o_ident) << IP) | (i_wdata & pg_mask);
    end
endmodule

// ### core/stc_walk_gate.sv
`timescale 1ns/1ps
module stc_walk_gate #(
    parameter int WIDTH = 64
) (
    input wire logic i_clk,
    input wire logic i_rst,
    stc_cfg_if.snk cfg,
    input wire logic i_req,
    input wire logic [WIDTH-1:0] i_vaddr,
    input wire logic i_walk_done,
    input wire logic i_fence,
    output logic o_start,
    output logic o_bare,
    output logic [WIDTH-1:0] o_paddr,
    output logic [WIDTH-1:0] o_root,
    output logic [15:0] o_ident,
    output logic [3:0] o_sel
);
    stc_pkg::stc_walk_type st_q, st_d;
    logic [WIDTH-1:0] root_q, root_d, paddr_q, paddr_d;
    logic [15:0] id_q, id_d;
    logic [3:0] sel_q, sel_d;
    logic bare_q, bare_d, start_q, start_d;
    always_comb begin
        st_d = st_q;
        root_d = root_q;
        id_d = id_q;
        sel_d = sel_q;
        paddr_d = paddr_q;
        // Bare result flags only the cycle after its request, like the start pulse
        bare_d = 1'b0;
        start_d = 1'b0;
        case (st_q)
            stc_pkg::STC_IDLE: begin
                if (i_req && cfg.active) begin
                    if (cfg.sel == stc_pkg::SEL_NONE) begin
                        paddr_d = i_vaddr;
                        bare_d = 1'b1;
                    end else begin
                        // Root and identifier snapshot from one register value
                        root_d = cfg.root_addr;
                        id_d = cfg.ident;
                        sel_d = cfg.sel;
                        bare_d = 1'b0;
                        start_d = 1'b1;
                        st_d = stc_pkg::STC_WALK;
                    end
                end
            end
            stc_pkg::STC_WALK: begin
                // Walk keeps its snapshot even if privilege drops; only walk done or a fence ends it
                if (i_walk_done || i_fence) begin
                    st_d = stc_pkg::STC_IDLE;
                end
            end
            default: st_d = stc_pkg::STC_IDLE;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= stc_pkg::STC_IDLE;
            root_q <= '0;
            id_q <= '0;
            sel_q <= stc_pkg::RESET_SEL;
            paddr_q <= '0;
            bare_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            st_q <= st_d;
            root_q <= root_d;
            id_q <= id_d;
            sel_q <= sel_d;
            paddr_q <= paddr_d;
            bare_q <= bare_d;
            start_q <= start_d;
        end
    end
    assign cfg.walk_busy = (st_q == stc_pkg::STC_WALK);
    assign o_start = start_q;
    assign o_bare = bare_q;
    assign o_paddr = paddr_q;
    assign o_root = root_q;
    assign o_ident = id_q;
    assign o_sel = sel_q;
endmodule

// ### tb/stc_checker_assertions.sv
`timescale 1ns/1ps
module stc_checker #(
    parameter int XLEN = 64,
    parameter int ID_BITS = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rd,
    input wire logic [1:0] i_priv,
    input wire logic i_req,
    input wire logic [XLEN-1:0] i_vaddr,
    input wire logic i_walk_done,
    input wire logic i_fence,
    input wire logic [XLEN-1:0] o_rdata,
    input wire logic o_active,
    input wire logic o_walk_busy,
    input wire logic o_start,
    input wire logic o_bare,
    input wire logic [XLEN-1:0] o_paddr,
    input wire logic [XLEN-1:0] o_root,
    input wire logic [15:0] o_ident
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_rdata_quiet: assert property (!i_rd |=> o_rdata == '0)
        else $error("read data not zero");
    a_active_map: assert property (o_active == (i_priv inside {2'h0, 2'h1}))
        else $error("active flag wrong");
    a_start_cause: assert property (o_start |-> $past(i_req) && $past(o_active))
        else $error("walk began without active request");
    a_bare_pass: assert property (o_bare |-> o_paddr == $past(i_vaddr))
        else $error("bare address changed");
    a_root_page: assert property (o_start |-> o_root[11:0] == 12'h000 && o_walk_busy)
        else $error("root not page aligned");
    a_ident_bits: assert property ((o_ident >> ID_BITS) == 16'h0000)
        else $error("unimplemented identifier bit set");
    a_walk_end: assert property (o_walk_busy && (i_walk_done || i_fence) |=> !o_walk_busy)
        else $error("walk did not end");
    a_snap_hold: assert property (o_walk_busy && !o_start |-> $stable(o_root) && $stable(o_ident))
        else $error("snapshot moved in walk");
    c_walk: cover property (o_start);
    c_bare: cover property (o_bare);
    c_fence: cover property (o_walk_busy && i_fence);
endmodule

bind stc_translation_ctrl stc_checker #(.XLEN(XLEN), .ID_BITS(ID_BITS)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_rd(i_rd), .i_priv(i_priv), .i_req(i_req),
    .i_vaddr(i_vaddr), .i_walk_done(i_walk_done), .i_fence(i_fence), .o_rdata(o_rdata),
    .o_active(o_active), .o_walk_busy(o_walk_busy), .o_start(o_start), .o_bare(o_bare),
    .o_paddr(o_paddr), .o_root(o_root), .o_ident(o_ident));

// ### tb/stc_walker.sv
`timescale 1ns/1ps
module stc_walker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_slow,
    input wire logic i_fence,
    output logic o_done
);
    logic [2:0] cnt_q;
    // Slow walks leave room for a write and a fence to land mid-walk
    always_ff @(posedge i_clk) begin
        if (i_rst || i_fence) begin
            cnt_q <= 3'h0;
        end else if (i_start) begin
            cnt_q <= i_slow ? 3'h6 : 3'h2;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    assign o_done = (cnt_q == 3'h1);
endmodule

// ### tb/stc_translation_ctrl_tb_top.sv
`timescale 1ns/1ps
module stc_translation_ctrl_tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [0:0] i_addr = 1'h0;
    logic i_wr = 1'b0, i_rd = 1'b0, i_req = 1'b0, i_fence = 1'b0, slow = 1'b0;
    logic [1:0] i_priv = 2'h1;
    logic [63:0] i_wdata = 64'h0, i_vaddr = 64'h0, o_rdata, o_paddr, o_root, v, cur;
    logic i_walk_done, o_active, o_walk_busy, o_start, o_bare;
    logic [15:0] o_ident;
    logic [3:0] o_sel;
    int error_cnt = 0;
    int num_checks = 0;
    always #5 i_clk = ~i_clk;
    stc_translation_ctrl #(.XLEN(64), .ID_BITS(8), .PG_BITS(40), .SCHEME_MASK(16'h0701)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_priv(i_priv), .i_req(i_req), .i_vaddr(i_vaddr),
        .i_walk_done(i_walk_done), .i_fence(i_fence), .o_active(o_active),
        .o_walk_busy(o_walk_busy), .o_start(o_start), .o_bare(o_bare), .o_paddr(o_paddr),
        .o_root(o_root), .o_ident(o_ident), .o_sel(o_sel));
    stc_walker u_walk (.i_clk(i_clk), .i_rst(i_rst), .i_start(o_start), .i_slow(slow),
        .i_fence(i_fence), .o_done(i_walk_done));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [63:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(output logic [63:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic req(input logic [63:0] a);
        @(posedge i_clk);
        i_req <= 1'b1;
        i_vaddr <= a;
        @(posedge i_clk);
        i_req <= 1'b0;
        #1;
    endtask
    task automatic wait_idle();
        for (int n = 0; o_walk_busy !== 1'b0; n++) begin
            @(posedge i_clk);
            if (n > 20) begin
                error_cnt++;
                final_report();
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(v);
        chk(v, 64'h0);
        wr(64'h8FFFFFFFFFFFFFFF);
        rd(v);
        chk(v, 64'h800FF0FFFFFFFFFF);
        for (int s = 0; s < 16; s++) begin
            v = (s == 0) ? 64'h0 : {s[3:0], 60'h000300000000456};
            wr(v);
            if (s == 0 || (s >= 8 && s <= 10)) cur = v;
            rd(v);
            chk(v, cur);
        end
        $display("test register done");
        @(posedge i_clk) slow <= 1'b1;
        req(64'h1000);
        chk(o_start, 1'b1);
        chk(o_root, 64'h456000);
        chk({o_sel, o_ident}, 20'hA0003);
        wr(64'h9000500000000789);
        chk(o_root, 64'h456000);
        @(posedge i_clk) i_priv <= 2'h3;
        @(posedge i_clk) i_priv <= 2'h1;
        #1;
        chk(o_walk_busy, 1'b1);
        @(posedge i_clk) i_fence <= 1'b1;
        @(posedge i_clk) i_fence <= 1'b0;
        #1;
        chk(o_walk_busy, 1'b0);
        wait_idle();
        @(posedge i_clk) slow <= 1'b0;
        req(64'h2000);
        chk({o_sel, o_ident, o_root}, {20'h90005, 64'h789000});
        wait_idle();
        $display("test walk done");
        @(posedge i_clk) i_priv <= 2'h3;
        req(64'h3000);
        chk({o_active, o_start}, 2'h0);
        @(posedge i_clk) i_priv <= 2'h0;
        wr(64'h0);
        req(64'hBEEF0123);
        chk({o_bare, o_start}, 2'h2);
        chk(o_paddr, 64'hBEEF0123);
        $display("test bare done");
        final_report();
    end
endmodule
